// >>> src/fnd_synth.sv
// Dual synthesizer core, fractional-N main loop: dividers, accumulator, detectors.
`timescale 1ns/1ps
`default_nettype none
module fnd_synth #(
  parameter int BACKLASH_REF_CYCLES = fnd_pkg::BACKLASH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider inputs, already synchronous square waves
  input wire logic main_vco_input,
  input wire logic aux_vco_input,
  input wire logic ref_input,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Charge pump controls
  output logic main_pump_up,
  output logic main_pump_down,
  output logic aux_pump_up,
  output logic aux_pump_down,
  output logic pump_gain_bit_low,
  output logic pump_gain_bit_high,
  // Fractional compensation
  output logic comp_pulse,
  output logic [2:0] comp_level,
  output logic [7:0] compensation_scale_setting,
  // Lock indicator
  output logic lock_out
);

  // Software registers.
  logic [16:0] main_ratio_pend;
  logic [16:0] main_ratio_act;
  logic [2:0] fraction_numerator;
  logic fraction_modulus_select;
  logic [7:0] scale_pend;
  logic [13:0] aux_ratio;
  logic [9:0] ref_ratio;
  logic [2:0] main_ref_tap_select;
  logic [2:0] aux_ref_tap_select;
  logic main_pd;
  logic aux_pd;

  // Edge detection of the divider inputs.
  logic main_vco_d;
  logic aux_vco_d;
  logic ref_d;
  logic main_edge;
  logic aux_edge;
  logic ref_edge;

  // Divider state.
  logic [16:0] main_cnt;
  logic [2:0] frac_acc;
  logic [3:0] acc_sum;
  logic [3:0] acc_q;
  logic acc_over;
  logic main_done;
  logic main_fb;
  logic main_pd_d;
  logic main_resume;
  logic [7:0] comp_cnt;
  logic [13:0] aux_cnt;
  logic aux_done;
  logic aux_fb;
  logic [9:0] ref_cnt;
  logic [2:0] bin_cnt;
  logic ref_done;
  logic main_ref_pulse;
  logic aux_ref_pulse;
  logic main_locked;
  logic aux_locked;

  assign main_edge = main_vco_input && !main_vco_d;
  assign aux_edge = aux_vco_input && !aux_vco_d;
  assign ref_edge = ref_input && !ref_d;
  assign main_done = !main_pd && main_edge && main_cnt == '0;
  assign aux_done = !aux_pd && aux_edge && aux_cnt == '0;
  assign ref_done = ref_edge && ref_cnt == '0;
  assign main_resume = main_pd_d && !main_pd;
  assign acc_sum = {1'b0, frac_acc} + {1'b0, fraction_numerator};
  assign acc_q = fnd_pkg::q_of(fraction_modulus_select);
  assign acc_over = acc_sum >= acc_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_vco_d <= 1'b0;
      aux_vco_d <= 1'b0;
      ref_d <= 1'b0;
      main_pd_d <= 1'b0;
    end else begin
      main_vco_d <= main_vco_input;
      aux_vco_d <= aux_vco_input;
      ref_d <= ref_input;
      main_pd_d <= main_pd;
    end
  end

  // Register writes; ratios below the documented minimum are not clamped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_ratio_pend <= fnd_pkg::MAIN_RATIO_RST;
      fraction_numerator <= '0;
      fraction_modulus_select <= 1'b0;
      scale_pend <= '0;
      aux_ratio <= fnd_pkg::AUX_RATIO_RST;
      ref_ratio <= fnd_pkg::REF_RATIO_RST;
      main_ref_tap_select <= '0;
      aux_ref_tap_select <= '0;
      pump_gain_bit_low <= 1'b0;
      pump_gain_bit_high <= 1'b0;
      main_pd <= 1'b0;
      aux_pd <= 1'b0;
    end else if (wr_en) begin
      case (addr)
        fnd_pkg::OFS_MAIN_RATIO: begin
          main_ratio_pend <= wr_data[fnd_pkg::MAIN_W-1:0];
        end
        fnd_pkg::OFS_FRAC: begin
          fraction_numerator <= wr_data[fnd_pkg::NUM_W-1:0];
          fraction_modulus_select <= wr_data[fnd_pkg::FRAC_MODSEL_BIT];
          scale_pend <= wr_data[fnd_pkg::FRAC_SCALE_LSB +:
                                fnd_pkg::SCALE_W];
        end
        fnd_pkg::OFS_AUX_RATIO: begin
          aux_ratio <= wr_data[fnd_pkg::AUX_W-1:0];
        end
        fnd_pkg::OFS_REF: begin
          ref_ratio <= wr_data[fnd_pkg::REFR_W-1:0];
          main_ref_tap_select <= wr_data[fnd_pkg::REF_MTAP_LSB +:
                                         fnd_pkg::TAP_W];
          aux_ref_tap_select <= wr_data[fnd_pkg::REF_ATAP_LSB +:
                                        fnd_pkg::TAP_W];
        end
        fnd_pkg::OFS_CTRL: begin
          pump_gain_bit_low <= wr_data[fnd_pkg::CTRL_GAIN_LO_BIT];
          pump_gain_bit_high <= wr_data[fnd_pkg::CTRL_GAIN_HI_BIT];
          main_pd <= wr_data[fnd_pkg::CTRL_MAIN_PD_BIT];
          aux_pd <= wr_data[fnd_pkg::CTRL_AUX_PD_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Main divider. The low bits of the down counter act as the prescaler
  // stage and the upper bits as the counter; one terminal count ends the
  // cycle. The pending ratio is taken only at that end or in power-down and resume, so a write never
  // cuts a division short.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_ratio_act <= fnd_pkg::MAIN_RATIO_RST;
      main_cnt <= fnd_pkg::MAIN_RATIO_RST - 17'h0_0001;
      compensation_scale_setting <= '0;
    end else if (main_pd || main_resume) begin
      main_ratio_act <= main_ratio_pend;
      main_cnt <= main_ratio_pend - 17'h0_0001;
    end else if (main_done) begin
      main_ratio_act <= main_ratio_pend;
      compensation_scale_setting <= scale_pend;
      main_cnt <= acc_over ? main_ratio_pend
                           : main_ratio_pend - 17'h0_0001;
    end else if (main_edge) begin
      main_cnt <= main_cnt - 17'h0_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || main_pd || main_resume) begin
      frac_acc <= '0;
    end else if (main_done) begin
      frac_acc <= fnd_pkg::frac_mod(acc_sum, acc_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_fb <= 1'b0;
      aux_fb <= 1'b0;
    end else begin
      main_fb <= main_done;
      aux_fb <= aux_done;
    end
  end

  // Compensation pulse, timed in main VCO edges from each cycle end.
  always_ff @(posedge clk) begin
    if (!rst_n || main_pd) begin
      comp_pulse <= 1'b0;
      comp_cnt <= '0;
    end else if (main_done) begin
      comp_pulse <= 1'b1;
      comp_cnt <= '0;
    end else if (comp_pulse && main_edge) begin
      if (comp_cnt == fnd_pkg::COMP_LAST) begin
        comp_pulse <= 1'b0;
      end else begin
        comp_cnt <= comp_cnt + 8'h01;
      end
    end
  end

  assign comp_level = frac_acc;

  // Auxiliary divider, integer only.
  always_ff @(posedge clk) begin
    if (!rst_n || aux_pd) begin
      aux_cnt <= aux_ratio - 14'h0001;
    end else if (aux_done) begin
      aux_cnt <= aux_ratio - 14'h0001;
    end else if (aux_edge) begin
      aux_cnt <= aux_cnt - 14'h0001;
    end
  end

  // Reference divider and its binary post-counter; restarted together with
  // the main divider so the main loop resumes in a known phase; the aux loop
  // does so only when it leaves a joint power-down, whether or not the main loop leaves in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n || main_resume || (main_pd && aux_pd)) begin
      ref_cnt <= ref_ratio - 10'h001;
      bin_cnt <= '0;
    end else if (ref_done) begin
      ref_cnt <= ref_ratio - 10'h001;
      bin_cnt <= bin_cnt + 3'h1;
    end else if (ref_edge) begin
      ref_cnt <= ref_cnt - 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_ref_pulse <= 1'b0;
      aux_ref_pulse <= 1'b0;
    end else begin
      main_ref_pulse <= ref_done &&
                        fnd_pkg::tap_hit(main_ref_tap_select, bin_cnt);
      aux_ref_pulse <= ref_done &&
                       fnd_pkg::tap_hit(aux_ref_tap_select, bin_cnt);
    end
  end

  fnd_pfd #(
    .BACKLASH(BACKLASH_REF_CYCLES)
  ) u_main_pfd (
    .clk(clk),
    .rst_n(rst_n),
    .enable(!main_pd),
    .ref_pulse(main_ref_pulse),
    .fb_pulse(main_fb),
    .ref_tick(ref_edge),
    .pump_up(main_pump_up),
    .pump_down(main_pump_down),
    .locked(main_locked)
  );

  fnd_pfd #(
    .BACKLASH(BACKLASH_REF_CYCLES)
  ) u_aux_pfd (
    .clk(clk),
    .rst_n(rst_n),
    .enable(!aux_pd),
    .ref_pulse(aux_ref_pulse),
    .fb_pulse(aux_fb),
    .ref_tick(ref_edge),
    .pump_up(aux_pump_up),
    .pump_down(aux_pump_down),
    .locked(aux_locked)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_out <= 1'b0;
    end else begin
      lock_out <= (!main_pd || !aux_pd) && (main_pd || main_locked) &&
                  (aux_pd || aux_locked);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !rd_en) begin
      rd_data <= '0;
    end else begin
      rd_data <= '0;
      case (addr)
        fnd_pkg::OFS_MAIN_RATIO: rd_data[16:0] <= main_ratio_act;
        fnd_pkg::OFS_FRAC: begin
          rd_data[fnd_pkg::NUM_W-1:0] <= fraction_numerator;
          rd_data[fnd_pkg::FRAC_MODSEL_BIT] <= fraction_modulus_select;
          rd_data[fnd_pkg::FRAC_SCALE_LSB +: fnd_pkg::SCALE_W] <=
            scale_pend;
        end
        fnd_pkg::OFS_AUX_RATIO: rd_data[13:0] <= aux_ratio;
        fnd_pkg::OFS_REF: begin
          rd_data[fnd_pkg::REFR_W-1:0] <= ref_ratio;
          rd_data[fnd_pkg::REF_MTAP_LSB +: fnd_pkg::TAP_W] <=
            main_ref_tap_select;
          rd_data[fnd_pkg::REF_ATAP_LSB +: fnd_pkg::TAP_W] <=
            aux_ref_tap_select;
        end
        fnd_pkg::OFS_CTRL: begin
          rd_data[fnd_pkg::CTRL_GAIN_LO_BIT] <= pump_gain_bit_low;
          rd_data[fnd_pkg::CTRL_GAIN_HI_BIT] <= pump_gain_bit_high;
          rd_data[fnd_pkg::CTRL_MAIN_PD_BIT] <= main_pd;
          rd_data[fnd_pkg::CTRL_AUX_PD_BIT] <= aux_pd;
        end
        fnd_pkg::OFS_STATUS: begin
          rd_data[fnd_pkg::STAT_LOCK_BIT] <= lock_out;
          rd_data[fnd_pkg::STAT_ACC_LSB +: fnd_pkg::NUM_W] <= frac_acc;
          rd_data[fnd_pkg::STAT_COMP_BIT] <= comp_pulse;
        end
        default: rd_data <= '0;
      endcase
    end
  end

  // Helper for checking the compensation width in VCO edges.
  logic [7:0] comp_edges;
  always_ff @(posedge clk) begin
    if (!rst_n || main_done) begin
      comp_edges <= '0;
    end else if (comp_pulse && main_edge) begin
      comp_edges <= comp_edges + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_comp_end;
    $fell(comp_pulse) ##0 !$past(main_pd);
  endsequence

  AST_FB_PULSE:
  assert property (main_done |=> main_fb ##1 !main_fb)
    else $error("Main feedback pulse is not one cycle per division.");

  AST_ACC_ADD:
  assert property (main_done && !main_resume |=> frac_acc ==
    fnd_pkg::frac_mod($past(acc_sum), $past(acc_q)))
    else $error("Accumulator did not add the numerator.");

  AST_ACC_WRAP:
  assert property (main_done |=> frac_acc < $past(acc_q))
    else $error("Accumulator exceeded its modulus.");

  AST_CARRY_RATIO:
  assert property (main_done && acc_over |=> main_cnt == main_ratio_act)
    else $error("Overflow did not stretch the next division.");

  AST_RATIO_SYNC:
  assert property ($changed(main_ratio_act) |->
                   $past(main_done || main_pd || main_resume))
    else $error("Main ratio changed mid-cycle.");

  AST_COMP_WIDTH:
  assert property (seq_comp_end |-> comp_edges == 8'h80)
    else $error("Compensation pulse width is not 128 VCO cycles.");

  AST_RESYNC:
  assert property (main_resume |=> ref_cnt == ref_ratio - 10'h001 &&
                   bin_cnt == 3'h0 && frac_acc == 3'h0)
    else $error("Dividers not resynchronised after power-down.");

  AST_LOCK_PD:
  assert property (main_pd && aux_pd |=> !lock_out)
    else $error("Lock shown with both loops powered down.");

endmodule
`default_nettype wire

// >>> src/fnd_pkg.sv
// Shared constants, types and helpers for the fractional-N divider core.
package fnd_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // Register offsets.
  localparam logic [3:0] OFS_MAIN_RATIO = 4'h0;
  localparam logic [3:0] OFS_FRAC = 4'h1;
  localparam logic [3:0] OFS_AUX_RATIO = 4'h2;
  localparam logic [3:0] OFS_REF = 4'h3;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // Field widths and positions.
  localparam int MAIN_W = 17;
  localparam int AUX_W = 14;
  localparam int REFR_W = 10;
  localparam int NUM_W = 3;
  localparam int TAP_W = 3;
  localparam int SCALE_W = 8;
  localparam int FRAC_MODSEL_BIT = 3;
  localparam int FRAC_SCALE_LSB = 8;
  localparam int REF_MTAP_LSB = 10;
  localparam int REF_ATAP_LSB = 13;
  localparam int CTRL_GAIN_LO_BIT = 0;
  localparam int CTRL_GAIN_HI_BIT = 1;
  localparam int CTRL_MAIN_PD_BIT = 2;
  localparam int CTRL_AUX_PD_BIT = 3;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_ACC_LSB = 1;
  localparam int STAT_COMP_BIT = 4;

  // Reset values.
  localparam logic [16:0] MAIN_RATIO_RST = 17'h0_0200;
  localparam logic [13:0] AUX_RATIO_RST = 14'h0080;
  localparam logic [9:0] REF_RATIO_RST = 10'h004;

  // Accumulator moduli and compensation pulse length in VCO cycles.
  localparam logic [3:0] Q_FIVE = 4'h5;
  localparam logic [3:0] Q_EIGHT = 4'h8;
  localparam int COMP_VCO_CYCLES = 128;
  localparam logic [7:0] COMP_LAST = 8'(COMP_VCO_CYCLES - 1);

  // Detector timing in reference input cycles.
  localparam int BACKLASH_DEFAULT = 2;
  localparam logic [1:0] SLIP_TICKS = 2'h2;

  typedef enum logic [3:0] {
    PFD_IDLE = 4'b0001,
    PFD_UP = 4'b0010,
    PFD_DN = 4'b0100,
    PFD_BOTH = 4'b1000
  } fnd_pfd_state_t;

  function automatic logic [3:0] q_of(input logic modsel);
    return modsel ? Q_FIVE : Q_EIGHT;
  endfunction

  // Reduces a sum of two values below 8 modulo q; works for q of 5 or 8.
  function automatic logic [2:0] frac_mod(input logic [3:0] s,
                                          input logic [3:0] q);
    logic [4:0] r;
    r = {1'b0, s};
    if (r >= {q, 1'b0}) begin
      r = r - {q, 1'b0};
    end else if (r >= {1'b0, q}) begin
      r = r - {1'b0, q};
    end
    return r[2:0];
  endfunction

  // Picks one of five reference pulses from the binary post-counter.
  function automatic logic tap_hit(input logic [2:0] code,
                                   input logic [2:0] cnt);
    case (code)
      3'h0: tap_hit = 1'b1;
      3'h1: tap_hit = cnt[0];
      3'h2: tap_hit = &cnt[1:0];
      3'h3: tap_hit = &cnt;
      3'h4: tap_hit = (cnt == 3'h3);
      default: tap_hit = 1'b0;
    endcase
  endfunction

endpackage

// >>> src/fnd_pfd.sv
// Tri-state phase/frequency detector with backlash and lock judgement.
`timescale 1ns/1ps
`default_nettype none
module fnd_pfd #(
  parameter int BACKLASH = fnd_pkg::BACKLASH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  // Pulses to compare and reference ticks for timing
  input wire logic ref_pulse,
  input wire logic fb_pulse,
  input wire logic ref_tick,
  // Pump controls and lock
  output logic pump_up,
  output logic pump_down,
  output logic locked
);

  localparam logic [3:0] BL = 4'(BACKLASH);

  fnd_pkg::fnd_pfd_state_t state;
  fnd_pkg::fnd_pfd_state_t next_state;
  logic [3:0] bl_cnt;
  logic [1:0] slip_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      fnd_pkg::PFD_IDLE: begin
        if (ref_pulse && fb_pulse) begin
          next_state = fnd_pkg::PFD_BOTH;
        end else if (ref_pulse) begin
          next_state = fnd_pkg::PFD_UP;
        end else if (fb_pulse) begin
          next_state = fnd_pkg::PFD_DN;
        end
      end
      fnd_pkg::PFD_UP: begin
        if (fb_pulse) begin
          next_state = fnd_pkg::PFD_BOTH;
        end
      end
      fnd_pkg::PFD_DN: begin
        if (ref_pulse) begin
          next_state = fnd_pkg::PFD_BOTH;
        end
      end
      fnd_pkg::PFD_BOTH: begin
        // Both pumps stay on for the backlash time even at zero error.
        if (bl_cnt == BL) begin
          next_state = fnd_pkg::PFD_IDLE;
        end
      end
      default: next_state = fnd_pkg::PFD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      state <= fnd_pkg::PFD_IDLE;
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else begin
      state <= next_state;
      pump_up <= (next_state == fnd_pkg::PFD_UP) ||
                 (next_state == fnd_pkg::PFD_BOTH);
      pump_down <= (next_state == fnd_pkg::PFD_DN) ||
                   (next_state == fnd_pkg::PFD_BOTH);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !enable || state != fnd_pkg::PFD_BOTH) begin
      bl_cnt <= 4'h0;
    end else if (ref_tick && bl_cnt != BL) begin
      bl_cnt <= bl_cnt + 4'h1;
    end
  end

  // A single pump held over two reference ticks means at least one
  // reference period of phase error; one tick may be the edge that made
  // the selected reference pulse itself.
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      slip_cnt <= 2'h0;
      locked <= 1'b0;
    end else if (state == fnd_pkg::PFD_BOTH &&
                 next_state == fnd_pkg::PFD_IDLE) begin
      locked <= (slip_cnt != fnd_pkg::SLIP_TICKS);
      slip_cnt <= 2'h0;
    end else if ((state == fnd_pkg::PFD_UP || state == fnd_pkg::PFD_DN)
                 && ref_tick && slip_cnt != fnd_pkg::SLIP_TICKS) begin
      slip_cnt <= slip_cnt + 2'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_idle_ref;
    enable && state == fnd_pkg::PFD_IDLE && ref_pulse;
  endsequence

  AST_PFD_UP_ON:
  assert property (seq_idle_ref |=> pump_up)
    else $error("Up pump not driven after a reference pulse.");

  AST_MIN_ON:
  assert property (($fell(pump_up) && $past(enable)) |->
                   $past(bl_cnt) == BL)
    else $error("Pumps released before the backlash time.");

  AST_CLEAR_BOTH:
  assert property ($fell(pump_up) |-> !pump_down)
    else $error("Up and down pumps were not cleared together.");

endmodule
`default_nettype wire

// >>> test/fnd_src_model.sv
// Square-wave sources standing in for the two VCOs and the reference.
`timescale 1ns/1ps
`default_nettype none
module fnd_src_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Half periods in clock cycles, at least one
  input wire logic [3:0] main_half,
  input wire logic [3:0] aux_half,
  input wire logic [3:0] ref_half,
  // Waves towards the core
  output logic main_wave,
  output logic aux_wave,
  output logic ref_wave
);
  logic [3:0] cnt [3];
  logic [3:0] half [3];
  logic [2:0] wave;

  assign half[0] = main_half;
  assign half[1] = aux_half;
  assign half[2] = ref_half;
  assign main_wave = wave[0];
  assign aux_wave = wave[1];
  assign ref_wave = wave[2];

  // Sources are parked low in reset so the core never sees a false edge.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_n) begin
        cnt[i] <= 4'h0;
        wave[i] <= 1'b0;
      end else if (cnt[i] + 4'h1 >= half[i]) begin
        cnt[i] <= 4'h0;
        wave[i] <= ~wave[i];
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> test/tb_fractional_n_divider_pfd.sv
// Self-checking bench for the fractional-N synthesizer core.
`timescale 1ns/1ps
`default_nettype none
module tb_fractional_n_divider_pfd;
  logic clk, rst_n, wr_en, rd_en;
  logic [3:0] addr;
  logic [31:0] wr_data, rd_data, d;
  logic main_vco_input, aux_vco_input, ref_input;
  logic main_pump_up, main_pump_down, aux_pump_up, aux_pump_down;
  logic pump_gain_bit_low, pump_gain_bit_high, comp_pulse, lock_out;
  logic [2:0] comp_level;
  logic [7:0] compensation_scale_setting;
  int mismatches, compares, p, h, acc, q, num, up, both;
  bit ovf, prev_ovf;
  logic prev;

  fnd_synth fnd_synth_inst (.clk(clk), .rst_n(rst_n),
    .main_vco_input(main_vco_input), .aux_vco_input(aux_vco_input),
    .ref_input(ref_input), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .main_pump_up(main_pump_up), .main_pump_down(main_pump_down),
    .aux_pump_up(aux_pump_up), .aux_pump_down(aux_pump_down),
    .pump_gain_bit_low(pump_gain_bit_low),
    .pump_gain_bit_high(pump_gain_bit_high), .comp_pulse(comp_pulse),
    .comp_level(comp_level),
    .compensation_scale_setting(compensation_scale_setting),
    .lock_out(lock_out));

  fnd_src_model fnd_src_model_inst (.clk(clk), .rst_n(rst_n),
    .main_half(4'h1), .aux_half(4'h1), .ref_half(4'h2),
    .main_wave(main_vco_input), .aux_wave(aux_vco_input),
    .ref_wave(ref_input));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  // Cycles to the next rise of the compensation window; hi counts its
  // remaining high time first, so it is the full width when entered at a rise.
  task automatic wait_rise(output int cyc, output int hi);
    cyc = 0;
    hi = 0;
    while (comp_pulse !== 1'b0 && cyc < 4000) begin
      @(posedge clk);
      #1 cyc++;
      hi++;
    end
    while (comp_pulse !== 1'b1 && cyc < 4000) begin
      @(posedge clk);
      #1 cyc++;
    end
    if (cyc >= 4000) begin
      mismatches++;
      $display("Timeout waiting for the compensation window");
      stop_test();
    end
  endtask

  task automatic watch(input int n, input bit aux, output int u, output int b);
    u = 0;
    b = 0;
    repeat (n) begin
      @(posedge clk);
      #1 u += aux ? int'(aux_pump_up === 1'b1) : int'(main_pump_up === 1'b1);
      b += aux ? int'(aux_pump_up === 1'b1 && aux_pump_down === 1'b1)
               : int'(main_pump_up === 1'b1 && main_pump_down === 1'b1);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({comp_pulse, lock_out, main_pump_up, aux_pump_up}, 32'h0);
    rd(fnd_pkg::OFS_MAIN_RATIO, d);
    check(d, 32'h0000_0200);
    @(posedge clk);
    #1 check(rd_data, 32'h0000_0000);
    rd(fnd_pkg::OFS_AUX_RATIO, d);
    check(d, 32'h0000_0080);
    rd(fnd_pkg::OFS_REF, d);
    check(d, 32'h0000_0004);
    rd(4'hF, d);
    check(d, 32'h0000_0000);
    for (int g = 0; g < 4; g++) begin
      wr(fnd_pkg::OFS_CTRL, 32'(g));
      #1 check({pump_gain_bit_high, pump_gain_bit_low}, 32'(g));
    end
    wr(fnd_pkg::OFS_CTRL, 32'h0000_0000);
    $display("Test registers done");
    // Fraction two fifths, then seven eighths, tracked cycle by cycle.
    acc = 0;
    prev_ovf = 1'b0;
    for (int c = 0; c < 2; c++) begin
      q = c == 0 ? 5 : 8;
      num = c == 0 ? 2 : 7;
      wr(fnd_pkg::OFS_FRAC, c == 0 ? 32'h0000_800A : 32'h0000_5007);
      // A division ending as the write lands still used the old fraction.
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
        wait_rise(p, h);
        if (i > 0) begin
          check(32'(p), 32'(2 * (512 + int'(prev_ovf))));
          check(32'(h), 32'h0000_0100);
        end
        ovf = acc + num >= q;
        acc = (acc + num) % q;
        prev_ovf = ovf;
        #1 check({29'h0, comp_level}, 32'(acc));
        if (i == 1) begin
          check({24'h0, compensation_scale_setting},
                c == 0 ? 32'h0000_0080 : 32'h0000_0050);
        end
      end
      // Status is read between windows so no measured period is cut short.
      rd(fnd_pkg::OFS_STATUS, d);
      check({29'h0, d[3:1]}, 32'(acc));
    end
    $display("Test fraction done");
    wr(fnd_pkg::OFS_FRAC, 32'h0000_0000);
    wr(fnd_pkg::OFS_MAIN_RATIO, 32'h0000_0258);
    rd(fnd_pkg::OFS_MAIN_RATIO, d);
    check(d, 32'h0000_0200);
    wait_rise(p, h);
    wait_rise(p, h);
    check(32'(p), 32'(2 * 600 + 2 * int'(prev_ovf && 1'b0)));
    rd(fnd_pkg::OFS_MAIN_RATIO, d);
    check(d, 32'h0000_0258);
    $display("Test ratio reload done");
    watch(3000, 1'b0, up, both);
    check(32'(up > 0), 32'h1);
    check(32'(both > 0), 32'h1);
    watch(3000, 1'b1, up, both);
    check(32'(both > 0), 32'h1);
    wr(fnd_pkg::OFS_REF, 32'h0000_1404);
    repeat (3000) @(posedge clk);
    watch(3000, 1'b0, up, both);
    check(32'(up), 32'h0);
    #1 check(32'(main_pump_down), 32'h1);
    watch(1000, 1'b1, up, both);
    check(32'(up > 0), 32'h1);
    // Ratio 64 and aux tap 2 give one reference pulse per 1024 cycles; the
    // faster aux feedback parks the detector in down between them.
    wr(fnd_pkg::OFS_REF, 32'h0000_5440);
    repeat (2000) @(posedge clk);
    #1 prev = aux_pump_up;
    up = 0;
    repeat (4096) begin
      @(posedge clk);
      #1 up += int'(aux_pump_up === 1'b1 && prev !== 1'b1);
      prev = aux_pump_up;
    end
    check(32'(up), 32'h0000_0004);
    $display("Test detectors done");
    wr(fnd_pkg::OFS_CTRL, 32'h0000_000C);
    repeat (20) @(posedge clk);
    #1 check({lock_out, main_pump_up, main_pump_down, aux_pump_up,
             aux_pump_down}, 32'h0);
    wr(fnd_pkg::OFS_CTRL, 32'h0000_0000);
    wait_rise(p, h);
    wait_rise(p, h);
    check(32'(p), 32'h0000_04B0);
    check(32'(h), 32'h0000_0100);
    $display("Test power-down done");
    stop_test();
  end
endmodule
`default_nettype wire
